// [rtl/rimc_pkg.sv]
// Package with register map, field layout, reset values and state types of the monitor config.
package rimc_pkg;

  // Number of monitored reference inputs; channel codes 1 to 14 select them.
  localparam int NUM_CH = 14;

  // Register offsets on the register port.
  localparam logic [7:0] OFS_MON_CLK = 8'h48;
  localparam logic [7:0] OFS_ALARM_LIMITS = 8'h49;
  localparam logic [7:0] OFS_SEL_LIMITS = 8'h4A;
  localparam logic [7:0] OFS_MEAS_SELECT = 8'h4B;
  localparam logic [7:0] OFS_FREQ_READOUT = 8'h4C;
  localparam logic [7:0] OFS_LOOP_SOFT = 8'h4D;
  localparam logic [7:0] OFS_RAISE_0 = 8'h50;
  localparam logic [7:0] OFS_CLEAR_0 = 8'h51;
  localparam logic [7:0] OFS_CEIL_0 = 8'h52;
  localparam logic [7:0] OFS_LEAK_0 = 8'h53;
  localparam logic [7:0] OFS_RAISE_1 = 8'h54;
  localparam logic [7:0] OFS_CLEAR_1 = 8'h55;
  localparam logic [7:0] OFS_CEIL_1 = 8'h56;
  localparam logic [7:0] OFS_LEAK_1 = 8'h57;

  // Field positions.
  localparam int HARD_LIM_LSB = 0;
  localparam int SOFT_LIM_LSB = 4;
  localparam int MEAS_SEL_LSB = 0;
  localparam int PATH_SEL_BIT = 4;
  localparam int PH_LOSS_BIT = 7;
  localparam int MON_CLK_BIT = 7;
  localparam int LEAK_LSB = 0;

  // Reset values.
  localparam logic [7:0] RST_MON_CLK = 8'h00;
  localparam logic [7:0] RST_LIMITS = 8'h23;
  localparam logic [7:0] RST_MEAS_SELECT = 8'h00;
  localparam logic [7:0] RST_LOOP_SOFT = 8'h8E;
  localparam logic [7:0] RST_RAISE = 8'h06;
  localparam logic [7:0] RST_CLEAR = 8'h04;
  localparam logic [7:0] RST_CEIL = 8'h08;
  localparam logic [1:0] RST_LEAK = 2'h1;

  // Limit step of one alarm-limit code, in parts per billion.
  localparam int unsigned LIMIT_STEP_PPB = 3810;

  // Leaky bucket evaluation cycle and its length in system clock cycles.
  localparam int unsigned BUCKET_CYCLE_MS = 128;
  localparam int unsigned SYS_CLK_KHZ = 250000;
  localparam int unsigned BUCKET_CYCLE_TICKS = BUCKET_CYCLE_MS * SYS_CLK_KHZ;
  localparam int TICK_W = 25;

  // One leaky bucket configuration.
  typedef struct packed {
    logic [7:0] raise;
    logic [7:0] clear;
    logic [7:0] ceil;
    logic [1:0] leak;
  } rimc_bucket_cfg_t;

  // Software-visible configuration.
  typedef struct packed {
    logic mon_clk_sel;
    logic [7:0] limits;
    logic [7:0] sel_limits;
    logic [7:0] meas_select;
    logic [7:0] loop_soft;
    rimc_bucket_cfg_t [1:0] bucket;
  } rimc_regs_t;

  localparam rimc_regs_t REGS_RST = '{
    mon_clk_sel: RST_MON_CLK[MON_CLK_BIT],
    limits: RST_LIMITS,
    sel_limits: RST_LIMITS,
    meas_select: RST_MEAS_SELECT,
    loop_soft: RST_LOOP_SOFT,
    bucket: {2{rimc_bucket_cfg_t'{RST_RAISE, RST_CLEAR, RST_CEIL, RST_LEAK}}}
  };

  // Whole state of the block.
  typedef struct packed {
    rimc_regs_t regs;
    logic [NUM_CH-1:0] fault_s1;
    logic [NUM_CH-1:0] fault_s2;
    logic [NUM_CH-1:0] fault_s3;
    logic [NUM_CH-1:0] fault_st;
    logic [NUM_CH-1:0][7:0] offs_s1;
    logic [NUM_CH-1:0][7:0] offs_s2;
    logic [NUM_CH-1:0][7:0] offs_s3;
    logic [NUM_CH-1:0][7:0] offs_st;
    logic [2:0] lim_s;
    logic lim_st;
    logic [TICK_W-1:0] tick;
    logic [NUM_CH-1:0] seen;
    logic [NUM_CH-1:0][7:0] acc;
    logic [NUM_CH-1:0][2:0] clean;
    logic [NUM_CH-1:0] act_alarm;
    logic [NUM_CH-1:0] hard_alarm;
    logic [NUM_CH-1:0] soft_alarm;
    logic [7:0] readout;
    logic force_phase_lost;
    logic [7:0] rdata;
    logic rvalid;
  } rimc_state_t;

endpackage

// [rtl/rimc_monitor_config.sv]
// Reference input monitor configuration, frequency readout and leaky bucket activity monitors.
`timescale 1ns/1ps

module rimc_monitor_config #(
  parameter int unsigned CYCLE_TICKS = rimc_pkg::BUCKET_CYCLE_TICKS,
  parameter int unsigned MEAS_STEP_PPB = 1000
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [rimc_pkg::NUM_CH-1:0][7:0] chan_offset,
  input wire logic [rimc_pkg::NUM_CH-1:0] chan_fault,
  input wire logic [rimc_pkg::NUM_CH-1:0] chan_bucket_cfg,
  input wire logic [3:0] selected_ref,
  input wire logic loop_at_hard_limit,
  output logic [rimc_pkg::NUM_CH-1:0] chan_hard_alarm,
  output logic [rimc_pkg::NUM_CH-1:0] chan_soft_alarm,
  output logic [rimc_pkg::NUM_CH-1:0] chan_activity_alarm,
  output logic force_phase_lost,
  output logic phase_loss_on_limit,
  output logic [6:0] loop_warn_offset,
  output logic loop_path_view_select,
  output logic mon_clk_from_crystal
);

  // Last tick of a bucket cycle; it is cut to the timer width where it is compared.
  localparam int unsigned LAST_TICK = CYCLE_TICKS - 1;

  rimc_pkg::rimc_state_t q;
  rimc_pkg::rimc_state_t d;
  logic [rimc_pkg::NUM_CH-1:0] hard_exc;
  logic [rimc_pkg::NUM_CH-1:0] soft_exc;

  // Per-channel frequency alarm compare on the stable copy of the measured offset.
  // Products are kept in 32 bits; an 8-bit magnitude times a ppb step cannot overflow.
  genvar gi;
  generate
    for (gi = 0; gi < rimc_pkg::NUM_CH; gi++)
    begin : g_freq
      logic [7:0] mag;
      logic is_sel;
      logic [3:0] hard_code;
      logic [3:0] soft_code;
      int unsigned mag_ppb;
      assign mag = q.offs_st[gi][7] ? 8'(-q.offs_st[gi]) : q.offs_st[gi];
      assign is_sel = (selected_ref == 4'(gi + 1));
      assign hard_code = is_sel ? q.regs.sel_limits[rimc_pkg::HARD_LIM_LSB +: 4]
                                : q.regs.limits[rimc_pkg::HARD_LIM_LSB +: 4];
      assign soft_code = is_sel ? q.regs.sel_limits[rimc_pkg::SOFT_LIM_LSB +: 4]
                                : q.regs.limits[rimc_pkg::SOFT_LIM_LSB +: 4];
      assign mag_ppb = 32'(mag) * MEAS_STEP_PPB;
      assign hard_exc[gi] = mag_ppb > (32'(hard_code) + 32'h1) * rimc_pkg::LIMIT_STEP_PPB;
      assign soft_exc[gi] = mag_ppb > (32'(soft_code) + 32'h1) * rimc_pkg::LIMIT_STEP_PPB;
    end
  endgenerate

  // Next-state logic: synchronisers, register writes and reads, bucket accounting.
  always_comb
  begin
    logic [3:0] sel_idx;
    logic cycle_end;
    logic faulty;
    logic [3:0] period;
    rimc_pkg::rimc_bucket_cfg_t cfg;
    sel_idx = 4'h0;
    cycle_end = 1'b0;
    faulty = 1'b0;
    period = 4'h0;
    cfg = '0;
    d = q;

    // Monitor signals come from the monitor clock; three stages, accept when 2 and 3 agree.
    d.fault_s1 = chan_fault;
    d.fault_s2 = q.fault_s1;
    d.fault_s3 = q.fault_s2;
    d.offs_s1 = chan_offset;
    d.offs_s2 = q.offs_s1;
    d.offs_s3 = q.offs_s2;
    for (int i = 0; i < rimc_pkg::NUM_CH; i++)
    begin
      if (q.fault_s2[i] == q.fault_s3[i])
      begin
        d.fault_st[i] = q.fault_s3[i];
      end
      // A word is taken only when all its bits were steady for a cycle, so no torn values.
      if (q.offs_s2[i] == q.offs_s3[i])
      begin
        d.offs_st[i] = q.offs_s3[i];
      end
    end
    d.lim_s = {q.lim_s[1:0], loop_at_hard_limit};
    if (q.lim_s[1] == q.lim_s[2])
    begin
      d.lim_st = q.lim_s[2];
    end

    // Register writes take effect at the next edge; read-only and unmapped writes are dropped.
    if (reg_wr)
    begin
      case (reg_addr)
        rimc_pkg::OFS_MON_CLK: d.regs.mon_clk_sel = reg_wdata[rimc_pkg::MON_CLK_BIT];
        rimc_pkg::OFS_ALARM_LIMITS: d.regs.limits = reg_wdata;
        rimc_pkg::OFS_SEL_LIMITS: d.regs.sel_limits = reg_wdata;
        rimc_pkg::OFS_MEAS_SELECT: d.regs.meas_select = {3'h0, reg_wdata[4:0]};
        rimc_pkg::OFS_LOOP_SOFT: d.regs.loop_soft = reg_wdata;
        rimc_pkg::OFS_RAISE_0: d.regs.bucket[0].raise = reg_wdata;
        rimc_pkg::OFS_CLEAR_0: d.regs.bucket[0].clear = reg_wdata;
        rimc_pkg::OFS_CEIL_0: d.regs.bucket[0].ceil = reg_wdata;
        rimc_pkg::OFS_LEAK_0: d.regs.bucket[0].leak = reg_wdata[rimc_pkg::LEAK_LSB +: 2];
        rimc_pkg::OFS_RAISE_1: d.regs.bucket[1].raise = reg_wdata;
        rimc_pkg::OFS_CLEAR_1: d.regs.bucket[1].clear = reg_wdata;
        rimc_pkg::OFS_CEIL_1: d.regs.bucket[1].ceil = reg_wdata;
        rimc_pkg::OFS_LEAK_1: d.regs.bucket[1].leak = reg_wdata[rimc_pkg::LEAK_LSB +: 2];
        default: d.regs = q.regs;
      endcase
    end

    // Register reads answer one cycle later; unused bits and unmapped offsets read zero.
    d.rvalid = reg_rd;
    d.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        rimc_pkg::OFS_MON_CLK: d.rdata = {q.regs.mon_clk_sel, 7'h00};
        rimc_pkg::OFS_ALARM_LIMITS: d.rdata = q.regs.limits;
        rimc_pkg::OFS_SEL_LIMITS: d.rdata = q.regs.sel_limits;
        rimc_pkg::OFS_MEAS_SELECT: d.rdata = q.regs.meas_select;
        rimc_pkg::OFS_FREQ_READOUT: d.rdata = q.readout;
        rimc_pkg::OFS_LOOP_SOFT: d.rdata = q.regs.loop_soft;
        rimc_pkg::OFS_RAISE_0: d.rdata = q.regs.bucket[0].raise;
        rimc_pkg::OFS_CLEAR_0: d.rdata = q.regs.bucket[0].clear;
        rimc_pkg::OFS_CEIL_0: d.rdata = q.regs.bucket[0].ceil;
        rimc_pkg::OFS_LEAK_0: d.rdata = {6'h00, q.regs.bucket[0].leak};
        rimc_pkg::OFS_RAISE_1: d.rdata = q.regs.bucket[1].raise;
        rimc_pkg::OFS_CLEAR_1: d.rdata = q.regs.bucket[1].clear;
        rimc_pkg::OFS_CEIL_1: d.rdata = q.regs.bucket[1].ceil;
        rimc_pkg::OFS_LEAK_1: d.rdata = {6'h00, q.regs.bucket[1].leak};
        default: d.rdata = 8'h00;
      endcase
    end

    // Frequency readout follows the chosen channel; codes 0 and 15 name no input.
    sel_idx = q.regs.meas_select[rimc_pkg::MEAS_SEL_LSB +: 4];
    if (sel_idx == 4'h0 || sel_idx == 4'hF)
    begin
      d.readout = 8'h00;
    end
    else
    begin
      d.readout = q.offs_st[sel_idx - 4'h1];
    end

    // Frequency alarms and the loop phase-loss force.
    d.hard_alarm = hard_exc;
    d.soft_alarm = soft_exc;
    d.force_phase_lost = q.regs.loop_soft[rimc_pkg::PH_LOSS_BIT] & q.lim_st;

    // Bucket cycle timer.
    cycle_end = (q.tick == LAST_TICK[rimc_pkg::TICK_W-1:0]);
    d.tick = cycle_end ? '0 : q.tick + 1'b1;

    // Leaky buckets; a fault in the last cycle of a period still counts for that period.
    for (int i = 0; i < rimc_pkg::NUM_CH; i++)
    begin
      cfg = q.regs.bucket[chan_bucket_cfg[i]];
      period = 4'h1 << cfg.leak;
      faulty = q.seen[i] | q.fault_st[i];
      if (cycle_end)
      begin
        d.seen[i] = 1'b0;
        if (faulty)
        begin
          d.clean[i] = 3'h0;
          if (q.acc[i] >= cfg.ceil)
          begin
            d.acc[i] = cfg.ceil;
          end
          else
          begin
            d.acc[i] = q.acc[i] + 8'h01;
          end
        end
        else if ({1'b0, q.clean[i]} + 4'h1 == period)
        begin
          d.clean[i] = 3'h0;
          if (q.acc[i] > cfg.ceil)
          begin
            d.acc[i] = cfg.ceil;
          end
          else if (q.acc[i] != 8'h00)
          begin
            d.acc[i] = q.acc[i] - 8'h01;
          end
        end
        else
        begin
          d.clean[i] = q.clean[i] + 3'h1;
        end
      end
      else
      begin
        d.seen[i] = faulty;
      end
      // Raise is tested first, so with a clear level above the raise level a count at or above raise still sets the alarm.
      if (d.acc[i] >= cfg.raise)
      begin
        d.act_alarm[i] = 1'b1;
      end
      else if (d.acc[i] <= cfg.clear)
      begin
        d.act_alarm[i] = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.regs <= rimc_pkg::REGS_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from state.
  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign chan_hard_alarm = q.hard_alarm;
  assign chan_soft_alarm = q.soft_alarm;
  assign chan_activity_alarm = q.act_alarm;
  assign force_phase_lost = q.force_phase_lost;
  assign phase_loss_on_limit = q.regs.loop_soft[rimc_pkg::PH_LOSS_BIT];
  assign loop_warn_offset = q.regs.loop_soft[6:0];
  assign loop_path_view_select = q.regs.meas_select[rimc_pkg::PATH_SEL_BIT];
  assign mon_clk_from_crystal = q.regs.mon_clk_sel;

endmodule // rimc_monitor_config

// [tb/rimc_monitor_config_asserts.sv]
// Checker of register port timing, register-driven outputs and phase-lost forcing.
`timescale 1ns/1ps
module rimc_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic loop_at_hard_limit,
  input wire logic [rimc_pkg::NUM_CH-1:0] chan_activity_alarm,
  input wire logic force_phase_lost,
  input wire logic phase_loss_on_limit,
  input wire logic [6:0] loop_warn_offset,
  input wire logic loop_path_view_select,
  input wire logic mon_clk_from_crystal
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Register port answers; idle read data stays zero so stale values never leak.
  chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  chk_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data not zero while idle");
  chk_limits_back: assert property (reg_wr && reg_addr == 8'h49 ##1 reg_rd && reg_addr == 8'h49
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("limit register readback wrong");
  chk_warn_write: assert property (reg_wr && reg_addr == 8'h4D |=>
    {phase_loss_on_limit, loop_warn_offset} == $past(reg_wdata)) else $error("loop limit not applied");
  chk_clk_source: assert property (reg_wr && reg_addr == 8'h48 |=>
    mon_clk_from_crystal == $past(reg_wdata[7])) else $error("monitor clock select not applied");
  chk_path_select: assert property (reg_wr && reg_addr == 8'h4B |=>
    loop_path_view_select == $past(reg_wdata[4])) else $error("path view select not applied");

  // Seven cycles cover the input synchroniser and the output register.
  chk_force_on: assert property ((phase_loss_on_limit && loop_at_hard_limit) [*7]
    |-> force_phase_lost) else $error("phase lost not forced at limit");
  chk_force_off: assert property ((!loop_at_hard_limit) [*7] |-> !force_phase_lost)
    else $error("phase lost forced away from limit");

  cov_read: cover property (reg_rd ##1 reg_rvalid);
  cov_forced: cover property ($rose(force_phase_lost));
  cov_alarm_drop: cover property ($fell(chan_activity_alarm[0]));
endmodule // rimc_checker

bind rimc_monitor_config rimc_checker u_checker (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .loop_at_hard_limit(loop_at_hard_limit),
  .chan_activity_alarm(chan_activity_alarm),
  .force_phase_lost(force_phase_lost),
  .phase_loss_on_limit(phase_loss_on_limit),
  .loop_warn_offset(loop_warn_offset),
  .loop_path_view_select(loop_path_view_select),
  .mon_clk_from_crystal(mon_clk_from_crystal)
);

// [tb/rimc_ref_inputs.sv]
// Behavioural model of the monitored reference inputs and the loop limit flag.
`timescale 1ns/1ps
module rimc_ref_inputs (
  output logic [rimc_pkg::NUM_CH-1:0][7:0] chan_offset,
  output logic [rimc_pkg::NUM_CH-1:0] chan_fault,
  output logic loop_at_hard_limit
);
  // All inputs start healthy, centred and away from the loop limit.
  initial
  begin
    chan_offset = '0;
    chan_fault = '0;
    loop_at_hard_limit = 1'b0;
  end

  // Sets one input's measured offset and its failed or erratic level.
  task automatic put(input int ch, input logic [7:0] ofs, input logic flt);
    chan_offset[ch] = ofs;
    chan_fault[ch] = flt;
  endtask

  // Moves the loop onto or off its hard frequency limit.
  task automatic lim(input logic on);
    loop_at_hard_limit = on;
  endtask
endmodule // rimc_ref_inputs

// [tb/rimc_monitor_config_test.sv]
// Self-checking bench for the reference monitor configuration block.
`timescale 1ns/1ps
module rimc_monitor_config_test;
  localparam int TICKS = 20;
  localparam logic [7:0] OFS [13] = '{8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4D, 8'h50, 8'h51, 8'h52,
    8'h53, 8'h54, 8'h55, 8'h56, 8'h57};
  localparam logic [7:0] RST [13] = '{8'h00, 8'h23, 8'h23, 8'h00, 8'h8E, 8'h06, 8'h04, 8'h08,
    8'h01, 8'h06, 8'h04, 8'h08, 8'h01};
  localparam logic [7:0] MSK [13] = '{8'h80, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h03};
  logic sys_clk, reset_n, reg_wr, reg_rd, reg_rvalid, loop_at_hard_limit, force_phase_lost;
  logic phase_loss_on_limit, loop_path_view_select, mon_clk_from_crystal;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, lh, ls, lim, b;
  logic [6:0] loop_warn_offset;
  logic [3:0] selected_ref;
  logic [rimc_pkg::NUM_CH-1:0][7:0] chan_offset;
  logic [rimc_pkg::NUM_CH-1:0] chan_fault, chan_bucket_cfg, chan_hard_alarm, chan_soft_alarm;
  logic [rimc_pkg::NUM_CH-1:0] chan_activity_alarm;
  logic [7:0] exp_q[$];
  int fail_count, n_checks, seed, mag, n;

  rimc_monitor_config #(.CYCLE_TICKS(TICKS), .MEAS_STEP_PPB(1000)) DUT (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .chan_offset(chan_offset),
    .chan_fault(chan_fault),
    .chan_bucket_cfg(chan_bucket_cfg),
    .selected_ref(selected_ref),
    .loop_at_hard_limit(loop_at_hard_limit),
    .chan_hard_alarm(chan_hard_alarm),
    .chan_soft_alarm(chan_soft_alarm),
    .chan_activity_alarm(chan_activity_alarm),
    .force_phase_lost(force_phase_lost),
    .phase_loss_on_limit(phase_loss_on_limit),
    .loop_warn_offset(loop_warn_offset),
    .loop_path_view_select(loop_path_view_select),
    .mon_clk_from_crystal(mon_clk_from_crystal)
  );
  rimc_ref_inputs u_ref (
    .chan_offset(chan_offset),
    .chan_fault(chan_fault),
    .loop_at_hard_limit(loop_at_hard_limit)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Strobes last one cycle; the next access waits an edge, so no strobe is set twice at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  // Write, then read the same offset on the very next edge, as the port allows back to back.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(negedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge sys_clk);
    {reg_wr, reg_rd} = 2'b01;
    exp_q.push_back(e);
    @(negedge sys_clk);
    reg_rd = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    exp_q.push_back(e);
    @(negedge sys_clk);
    reg_rd = 1'b0;
  endtask

  // Read answers are matched against the oldest noted expectation; a surplus answer fails.
  always @(negedge sys_clk)
    if (reg_rvalid === 1'b1)
      check(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, "read data");

  // Free-running system clock, 4 ns period.
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Watchdog against a hung wait.
  initial
  begin
    #200000;
    fail_count++;
    finish_test();
  end

  // Main sequence.
  initial
  begin
    {fail_count, n_checks, seed} = {32'h0, 32'h0, 32'd62288};
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, selected_ref} = '0;
    chan_bucket_cfg = '0;
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    for (int i = 0; i < 13; i++) rd(OFS[i], RST[i]);
    for (int i = 0; i < 13; i++)
    begin
      v = 8'($random(seed));
      wr_rd(OFS[i], v, v & MSK[i]);
    end
    wr(8'h60, 8'hFF);
    rd(8'h60, 8'h00);
    wr(8'h4B, 8'h02);
    // Random offsets on input 2 against random limits, with and without it selected.
    for (int i = 0; i < 12; i++)
    begin
      {v, lh, ls} = 24'($random(seed));
      selected_ref = i[0] ? 4'h2 : 4'h0;
      wr(8'h49, lh);
      wr(8'h4A, ls);
      wr(8'h4C, ~v);
      u_ref.put(1, v, 1'b0);
      repeat (8) @(negedge sys_clk);
      lim = i[0] ? ls : lh;
      mag = v[7] ? 256 - int'(v) : int'(v);
      check(8'(mag * 1000 > (int'(lim[3:0]) + 1) * 3810), {7'h00, chan_hard_alarm[1]}, "hard");
      check(8'(mag * 1000 > (int'(lim[7:4]) + 1) * 3810), {7'h00, chan_soft_alarm[1]}, "soft");
      rd(8'h4C, v);
    end
    // Channel code 15 names no input, so the readout must fall back to zero.
    wr(8'h4B, 8'h0F);
    rd(8'h4C, 8'h00);
    wr(8'h4D, 8'h8E);
    u_ref.lim(1'b1);
    repeat (8) @(negedge sys_clk);
    check({7'h00, force_phase_lost}, 8'h01, "phase lost forced");
    wr(8'h4D, 8'h0E);
    repeat (2) @(negedge sys_clk);
    check({7'h00, force_phase_lost}, 8'h00, "phase lost released");
    u_ref.lim(1'b0);
    // Bucket on input 1 for every leak code, alternating configurations; timing is
    // reckoned from the alarm's own rise, which marks a bucket cycle end.
    for (int l = 0; l < 4; l++)
    begin
      b = 8'h50 + 8'(4 * (l % 2));
      chan_bucket_cfg = {rimc_pkg::NUM_CH{l[0]}};
      wr(b, 8'h03);
      wr(b + 8'h01, 8'h01);
      wr(b + 8'h02, 8'h04);
      wr(b + 8'h03, 8'(l));
      repeat (TICKS + 5) @(negedge sys_clk);
      u_ref.put(0, 8'h00, 1'b1);
      n = 0;
      while (chan_activity_alarm[0] !== 1'b1 && n < 200)
      begin
        @(negedge sys_clk);
        n++;
      end
      check(8'(n < 200), 8'h01, "alarm raise");
      repeat (40) @(negedge sys_clk);
      u_ref.put(0, 8'h00, 1'b0);
      repeat (18 + 60 * (1 << l)) @(negedge sys_clk);
      check({7'h00, chan_activity_alarm[0]}, 8'h01, "alarm held");
      repeat (3) @(negedge sys_clk);
      check({7'h00, chan_activity_alarm[0]}, 8'h00, "alarm clear");
    end
    repeat (4) @(negedge sys_clk);
    finish_test();
  end
endmodule // rimc_monitor_config_test
